// ### phy_status_summary_low.v
// phy status summary register, bits 8:0, with event interrupt logic
//
// Overview of operation
// - bit 8 latches page received; an expansion register read or reset clears it
// - bit 7 set while interrupt pending; interrupt source register read clears it
// - bit 6 latches partner remote fault; basic status read or reset clears
// - bit 5 mirrors jabber detect at any speed setting; summary read keeps it
// - bit 4 is one when auto-negotiation has completed
// - bit 3 is one while mii loopback is enabled and active
// - bit 2 full duplex one, half zero; valid with link and negotiation settled
// - bit 1 speed, one for 10 Mb/s; valid with link and negotiation settled
// - bit 0 mirrors link status; a summary read does not clear it
`timescale 1ns/10ps
`include "phy_status_defines.vh"
module phy_status_summary_low
(
  // clock and reset
  input  wire                 clk,
  input  wire                 rst_b,
  // management register port
  input  wire [`ADDR_W-1:0]   addr,
  input  wire [`DATA_W-1:0]   wdata,
  input  wire                 wr_stb,
  input  wire                 rd_stb,
  output reg  [`DATA_W-1:0]   rdata,
  // event pulses from phy core logic
  input  wire                 page_rx_pulse,
  input  wire                 int_src_pulse,
  input  wire                 remote_fault_pulse,
  // levels from phy core logic
  input  wire                 jabber_detect,
  // negotiation state
  input  wire                 an_enable,
  input  wire                 an_complete,
  // loopback state
  input  wire                 loopback_en,
  input  wire                 loopback_active,
  // link mode
  input  wire                 duplex_full,
  input  wire                 speed_10,
  input  wire                 link_up,
  // interrupt
  output reg                  irq
);

  // read decode
  wire                        rd_an_expansion;
  wire                        rd_basic_status;
  wire                        rd_int_source;
  wire                        rd_summary;
  wire                        rd_evt_status;
  wire                        rd_evt_mask;

  // write decode
  wire                        wr_evt_status;
  wire                        wr_evt_mask;

  // latched summary bits
  wire                        page_rx_q;
  wire                        int_pend_q;
  wire                        remote_fault_q;
  wire                        int_pend_set;

  // mirrored summary bits
  reg                         jabber_reg;
  reg                         an_done_reg;
  reg                         loopback_reg;
  reg                         link_reg;

  // duplex and speed hold their last settled value
  reg                         duplex_reg;
  reg                         duplex_next;
  reg                         speed_reg;
  reg                         speed_next;
  wire                        mode_valid;

  // level edges
  wire                        jabber_rise;
  wire                        an_done_rise;
  wire                        link_change;

  // event interrupt registers
  wire [`EVT_W-1:0]           evt_status;
  reg  [`EVT_W-1:0]           evt_mask_reg;
  reg  [`EVT_W-1:0]           evt_mask_next;
  wire [`EVT_W-1:0]           evt_set;
  reg  [`EVT_W-1:0]           evt_clr;
  wire                        evt_unmasked_new;
  wire                        irq_next;

  // assembled read data
  wire [`SUMMARY_W-1:0]       summary;
  reg  [`DATA_W-1:0]          rdata_next;

  // register port decode
  // reads of the source registers are only observed here; their data
  // come from elsewhere, so this block answers them with zero
  assign rd_an_expansion = rd_stb && (addr == `OFS_AN_EXPANSION);
  assign rd_basic_status = rd_stb && (addr == `OFS_BASIC_STATUS);
  assign rd_int_source   = rd_stb && (addr == `OFS_INT_SOURCE);
  assign rd_summary      = rd_stb && (addr == `OFS_STATUS_SUMMARY);
  assign rd_evt_status   = rd_stb && (addr == `OFS_EVT_STATUS);
  assign rd_evt_mask     = rd_stb && (addr == `OFS_EVT_MASK);

  // only the event registers take writes; the summary offset is not decoded
  assign wr_evt_status   = wr_stb && (addr == `OFS_EVT_STATUS);
  assign wr_evt_mask     = wr_stb && (addr == `OFS_EVT_MASK);

  // edge history resets low, so a link already up at release counts as one change
  change_detect
  #(
    .WIDTH (1)
  )
  u_jabber_edges
  (
    .clk    (clk),
    .rst_b  (rst_b),
    .d      (jabber_detect),
    .rise   (jabber_rise),
    .change ()
  );

  change_detect
  #(
    .WIDTH (1)
  )
  u_an_done_edges
  (
    .clk    (clk),
    .rst_b  (rst_b),
    .d      (an_complete),
    .rise   (an_done_rise),
    .change ()
  );

  change_detect
  #(
    .WIDTH (1)
  )
  u_link_edges
  (
    .clk    (clk),
    .rst_b  (rst_b),
    .d      (link_up),
    .rise   (),
    .change (link_change)
  );

  // page received latch, cleared by an expansion register read or by reset
  sticky_bits
  #(
    .WIDTH (1)
  )
  u_page_rx
  (
    .clk   (clk),
    .rst_b (rst_b),
    .set   (page_rx_pulse),
    .clr   (rd_an_expansion),
    .q     (page_rx_q)
  );

  // interrupt pending latch; any unmasked new event also counts as pending
  assign evt_unmasked_new = |(evt_set & evt_mask_reg);
  assign int_pend_set     = int_src_pulse | evt_unmasked_new;

  sticky_bits
  #(
    .WIDTH (1)
  )
  u_int_pend
  (
    .clk   (clk),
    .rst_b (rst_b),
    .set   (int_pend_set),
    .clr   (rd_int_source),
    .q     (int_pend_q)
  );

  // remote fault latch; reset clears it through the flag reset
  sticky_bits
  #(
    .WIDTH (1)
  )
  u_remote_fault
  (
    .clk   (clk),
    .rst_b (rst_b),
    .set   (remote_fault_pulse),
    .clr   (rd_basic_status),
    .q     (remote_fault_q)
  );

  // duplex and speed only follow the core while the mode is settled;
  // otherwise the last settled value is held rather than showing noise
  assign mode_valid = link_up && (an_complete || !an_enable);

  always @*
  begin
    duplex_next = duplex_reg;
    speed_next  = speed_reg;
    if (mode_valid)
    begin
      duplex_next = duplex_full;
      speed_next  = speed_10;
    end
  end

  // basic status mirrors, one register stage so the read data stay glitch free
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      jabber_reg <= 1'b0;
      link_reg   <= 1'b0;
    end
    else
    begin
      jabber_reg <= jabber_detect;
      link_reg   <= link_up;
    end
  end

  // negotiation done mirror
  always @(posedge clk)
  begin
    if (!rst_b)
      an_done_reg <= 1'b0;
    else
      an_done_reg <= an_complete;
  end

  // loopback only counts once the path is really active, not merely enabled
  always @(posedge clk)
  begin
    if (!rst_b)
      loopback_reg <= 1'b0;
    else
      loopback_reg <= loopback_en & loopback_active;
  end

  // settled duplex and speed
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      duplex_reg <= 1'b0;
      speed_reg  <= 1'b0;
    end
    else
    begin
      duplex_reg <= duplex_next;
      speed_reg  <= speed_next;
    end
  end

  // event sources for the interrupt status register
  assign evt_set[`EVT_PAGE_RX]      = page_rx_pulse;
  assign evt_set[`EVT_REMOTE_FAULT] = remote_fault_pulse;
  assign evt_set[`EVT_LINK_CHANGE]  = link_change;
  assign evt_set[`EVT_AN_DONE]      = an_done_rise;
  assign evt_set[`EVT_JABBER]       = jabber_rise;

  // write one to clear
  always @*
  begin
    evt_clr = {`EVT_W{1'b0}};
    if (wr_evt_status)
      evt_clr = wdata[`EVT_W-1:0];
  end

  sticky_bits
  #(
    .WIDTH (`EVT_W)
  )
  u_evt_status
  (
    .clk   (clk),
    .rst_b (rst_b),
    .set   (evt_set),
    .clr   (evt_clr),
    .q     (evt_status)
  );

  // event mask
  always @*
  begin
    evt_mask_next = evt_mask_reg;
    if (wr_evt_mask)
      evt_mask_next = wdata[`EVT_W-1:0];
  end

  always @(posedge clk)
  begin
    if (!rst_b)
      evt_mask_reg <= `RST_EVT_MASK;
    else
      evt_mask_reg <= evt_mask_next;
  end

  // level interrupt, one cycle behind the status bits
  assign irq_next = |(evt_status & evt_mask_reg);

  always @(posedge clk)
  begin
    if (!rst_b)
      irq <= 1'b0;
    else
      irq <= irq_next;
  end

  // summary field assembly
  assign summary[`BIT_PAGE_RX]      = page_rx_q;
  assign summary[`BIT_INT_PEND]     = int_pend_q;
  assign summary[`BIT_REMOTE_FAULT] = remote_fault_q;
  assign summary[`BIT_JABBER]       = jabber_reg;
  assign summary[`BIT_AN_DONE]      = an_done_reg;
  assign summary[`BIT_LOOPBACK]     = loopback_reg;
  assign summary[`BIT_DUPLEX]       = duplex_reg;
  assign summary[`BIT_SPEED]        = speed_reg;
  assign summary[`BIT_LINK]         = link_reg;

  // read data mux; a summary read has no side effect on any latch, and
  // writes to the summary offset are simply not decoded
  always @*
  begin
    rdata_next = `RST_RDATA;
    if (rd_summary)
      rdata_next = {{(`DATA_W-`SUMMARY_W){1'b0}}, summary};
    else if (rd_evt_status)
      rdata_next = {{(`DATA_W-`EVT_W){1'b0}}, evt_status};
    else if (rd_evt_mask)
      rdata_next = {{(`DATA_W-`EVT_W){1'b0}}, evt_mask_reg};
  end

  // read data stand only in the cycle after the strobe
  always @(posedge clk)
  begin
    if (!rst_b)
      rdata <= `RST_RDATA;
    else
      rdata <= rdata_next;
  end

endmodule

// ### phy_status_defines.vh
// register offsets, field positions and reset values for the phy status summary block
`ifndef PHY_STATUS_DEFINES_VH
`define PHY_STATUS_DEFINES_VH

// bus widths
`define ADDR_W             5
`define DATA_W             16

// register offsets, management register space
`define OFS_BASIC_STATUS   5'h01
`define OFS_AN_EXPANSION   5'h06
`define OFS_STATUS_SUMMARY 5'h10
`define OFS_INT_SOURCE     5'h12
`define OFS_EVT_STATUS     5'h18
`define OFS_EVT_MASK       5'h19

// phy_status_summary field positions
`define BIT_PAGE_RX        8
`define BIT_INT_PEND       7
`define BIT_REMOTE_FAULT   6
`define BIT_JABBER         5
`define BIT_AN_DONE        4
`define BIT_LOOPBACK       3
`define BIT_DUPLEX         2
`define BIT_SPEED          1
`define BIT_LINK           0
`define SUMMARY_W          9

// event status / mask field positions
`define EVT_PAGE_RX        0
`define EVT_REMOTE_FAULT   1
`define EVT_LINK_CHANGE    2
`define EVT_AN_DONE        3
`define EVT_JABBER         4
`define EVT_W              5

// reset values
`define RST_SUMMARY        9'h000
`define RST_EVT_STATUS     5'h00
`define RST_EVT_MASK       5'h00
`define RST_RDATA          16'h0000

`endif

// ### sticky_bits.v
// vector of sticky flags where a set in the clearing cycle wins
`timescale 1ns/10ps
module sticky_bits
#(
  parameter WIDTH = 1
)
(
  // clock and reset
  input  wire             clk,
  input  wire             rst_b,
  // set and clear requests
  input  wire [WIDTH-1:0] set,
  input  wire [WIDTH-1:0] clr,
  // flag state
  output reg  [WIDTH-1:0] q
);

  wire [WIDTH-1:0] q_next;

  // set wins so an event in the clearing cycle is not lost
  assign q_next = set | (q & ~clr);

  always @(posedge clk)
  begin
    if (!rst_b)
      q <= {WIDTH{1'b0}};
    else
      q <= q_next;
  end

endmodule

// ### change_detect.v
// registered history of a level vector with rise and change pulses
`timescale 1ns/10ps
module change_detect
#(
  parameter WIDTH = 1
)
(
  // clock and reset
  input  wire             clk,
  input  wire             rst_b,
  // watched levels, same clock domain
  input  wire [WIDTH-1:0] d,
  // one-cycle pulses
  output wire [WIDTH-1:0] rise,
  output wire [WIDTH-1:0] change
);

  reg [WIDTH-1:0] prev_reg;

  always @(posedge clk)
  begin
    if (!rst_b)
      prev_reg <= {WIDTH{1'b0}};
    else
      prev_reg <= d;
  end

  assign rise   = d & ~prev_reg;
  assign change = d ^ prev_reg;

endmodule

// ### phy_status_summary_chk_asserts.sv
// assertion checker for the phy status summary low block
`timescale 1ns/10ps
`include "phy_status_defines.vh"
module phy_status_summary_chk
(
  // clock and reset
  input wire               clk,
  input wire               rst_b,
  // register port
  input wire [`ADDR_W-1:0] addr,
  input wire               wr_stb,
  input wire               rd_stb,
  input wire [`DATA_W-1:0] rdata,
  // core events and levels
  input wire               page_rx_pulse,
  input wire               int_src_pulse,
  input wire               remote_fault_pulse,
  input wire               jabber_detect,
  input wire               an_enable,
  input wire               an_complete,
  input wire               loopback_en,
  input wire               loopback_active,
  input wire               duplex_full,
  input wire               speed_10,
  input wire               link_up
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire rd_sum = rd_stb && addr == `OFS_STATUS_SUMMARY;
  wire settled = link_up && (an_complete || !an_enable);
  // mirrors lag one cycle; skip reads whose mirror was still in reset
  sequence s_rd;
    rd_sum && $past(rst_b);
  endsequence
  AST_LINK: assert property (s_rd |=> rdata[0] == $past(link_up, 2))
    else $error("link bit wrong");
  AST_JABBER: assert property (s_rd |=> rdata[5] == $past(jabber_detect, 2))
    else $error("jabber bit wrong");
  AST_AN_DONE: assert property (s_rd |=> rdata[4] == $past(an_complete, 2))
    else $error("negotiation done bit wrong");
  AST_LOOP: assert property (s_rd |=> rdata[3] == $past(loopback_en && loopback_active, 2))
    else $error("loopback bit wrong");
  AST_DUPLEX: assert property (s_rd and $past(settled) |=> rdata[2] == $past(duplex_full, 2))
    else $error("duplex bit wrong");
  AST_SPEED: assert property (s_rd and $past(settled) |=> rdata[1] == $past(speed_10, 2))
    else $error("speed bit wrong");
  AST_PAGE: assert property (page_rx_pulse ##[1:2] rd_sum |=> rdata[8])
    else $error("page bit not set");
  AST_INT: assert property (int_src_pulse ##[1:2] rd_sum |=> rdata[7])
    else $error("pending bit not set");
  AST_FAULT: assert property (remote_fault_pulse ##[1:2] rd_sum |=> rdata[6])
    else $error("fault bit not set");
  AST_UPPER: assert property (rdata[15:9] == 7'h00)
    else $error("upper bits not zero");
  AST_WR: assert property (wr_stb |=> rdata == 16'h0000)
    else $error("write produced read data");
endmodule

bind phy_status_summary_low phy_status_summary_chk chk_i
(
  .clk(clk), .rst_b(rst_b), .addr(addr), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
  .page_rx_pulse(page_rx_pulse), .int_src_pulse(int_src_pulse), .remote_fault_pulse(remote_fault_pulse),
  .jabber_detect(jabber_detect), .an_enable(an_enable), .an_complete(an_complete),
  .loopback_en(loopback_en), .loopback_active(loopback_active), .duplex_full(duplex_full),
  .speed_10(speed_10), .link_up(link_up)
);

// ### mgmt_master.sv
// management master model driving the register port
`timescale 1ns/10ps
`include "phy_status_defines.vh"
module mgmt_master
(
  // clock
  input  wire               clk,
  // register port
  output reg  [`ADDR_W-1:0] addr,
  output reg  [`DATA_W-1:0] wdata,
  output reg                wr_stb,
  output reg                rd_stb,
  input  wire [`DATA_W-1:0] rdata
);
  initial
  begin
    addr = 5'h00;
    wdata = 16'h0000;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end
  // idle bus shows inverted values so stale data cannot pass
  task wr(input [`ADDR_W-1:0] a, input [`DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  task rd(input [`ADDR_W-1:0] a, output [`DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    addr <= ~a;
    #1 d = rdata;
  endtask
endmodule

// ### tb_top.sv
// testbench for the phy status summary low block
`timescale 1ns/10ps
`include "phy_status_defines.vh"
module tb_top;
  reg                clk = 1'b0;
  reg                rst_b = 1'b0;
  reg  [2:0]         pls = 3'h0;
  reg  [7:0]         lvl = 8'h00;
  reg  [`DATA_W-1:0] d;
  wire [`ADDR_W-1:0] addr;
  wire [`DATA_W-1:0] wdata;
  wire [`DATA_W-1:0] rdata;
  wire               wr_stb;
  wire               rd_stb;
  wire               irq;
  integer            err_total = 0;
  integer            n_tests = 0;
  integer            i;
  always #25 clk = ~clk;
  mgmt_master mgmt_master_i (.clk(clk), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata));
  phy_status_summary_low phy_status_summary_low_i
  (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .page_rx_pulse(pls[0]), .int_src_pulse(pls[1]), .remote_fault_pulse(pls[2]),
    .jabber_detect(lvl[7]), .an_enable(lvl[6]), .an_complete(lvl[5]), .loopback_en(lvl[4]),
    .loopback_active(lvl[3]), .duplex_full(lvl[2]), .speed_10(lvl[1]), .link_up(lvl[0]), .irq(irq)
  );
  task chk(input [15:0] seen, input [15:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("CHECK FAILED %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task rdchk(input [4:0] a, input [15:0] exp);
    mgmt_master_i.rd(a, d);
    chk(d, exp);
  endtask
  // mirrors lag one cycle, so give two edges before reading
  task setl(input [7:0] v);
    @(posedge clk);
    lvl <= v;
    repeat (2) @(posedge clk);
  endtask
  task pulse(input integer k);
    @(posedge clk);
    pls[k] <= 1'b1;
    @(posedge clk);
    pls[k] <= 1'b0;
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rdchk(`OFS_STATUS_SUMMARY, 16'h0000);
    rdchk(5'h1f, 16'h0000);
    $display("reset test done");
    setl(8'hff);
    rdchk(`OFS_STATUS_SUMMARY, 16'h003f);
    rdchk(`OFS_STATUS_SUMMARY, 16'h003f);
    setl(8'hd9);
    rdchk(`OFS_STATUS_SUMMARY, 16'h002f);
    setl(8'h99);
    rdchk(`OFS_STATUS_SUMMARY, 16'h0029);
    setl(8'h91);
    rdchk(`OFS_STATUS_SUMMARY, 16'h0021);
    setl(8'h86);
    rdchk(`OFS_STATUS_SUMMARY, 16'h0020);
    mgmt_master_i.wr(`OFS_STATUS_SUMMARY, 16'hffff);
    rdchk(`OFS_STATUS_SUMMARY, 16'h0020);
    $display("level test done");
    for (i = 0; i < 3; i = i + 1)
    begin
      pulse(i);
      rdchk(`OFS_STATUS_SUMMARY, 16'h0020 | (16'h0100 >> i));
      rdchk(`OFS_STATUS_SUMMARY, 16'h0020 | (16'h0100 >> i));
      rdchk(i == 0 ? `OFS_AN_EXPANSION : i == 1 ? `OFS_INT_SOURCE : `OFS_BASIC_STATUS, 16'h0000);
      rdchk(`OFS_STATUS_SUMMARY, 16'h0020);
    end
    $display("latch test done");
    rdchk(`OFS_EVT_STATUS, 16'h001f);
    mgmt_master_i.wr(`OFS_EVT_STATUS, 16'h001f);
    rdchk(`OFS_EVT_STATUS, 16'h0000);
    mgmt_master_i.wr(`OFS_EVT_MASK, 16'h0001);
    rdchk(`OFS_EVT_MASK, 16'h0001);
    pulse(0);
    repeat (2) @(posedge clk);
    #1 chk({15'h0000, irq}, 16'h0001);
    rdchk(`OFS_EVT_STATUS, 16'h0001);
    rdchk(`OFS_STATUS_SUMMARY, 16'h01a0);
    mgmt_master_i.wr(`OFS_EVT_MASK, 16'h0000);
    @(posedge clk);
    #1 chk({15'h0000, irq}, 16'h0000);
    mgmt_master_i.wr(`OFS_EVT_STATUS, 16'h0001);
    mgmt_master_i.wr(`OFS_EVT_MASK, 16'h0001);
    @(posedge clk);
    #1 chk({15'h0000, irq}, 16'h0000);
    rdchk(`OFS_INT_SOURCE, 16'h0000);
    rdchk(`OFS_AN_EXPANSION, 16'h0000);
    rdchk(`OFS_STATUS_SUMMARY, 16'h0020);
    $display("interrupt test done");
    end_sim;
  end
endmodule
